// ==== pkg/alu_consts.svh ====
// Constants for the subtract, logic and compare datapath
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// Instruction clocks, fast RAM or no data access
`define CLK_IMM_A          4'h4
`define CLK_IMM_SADDR_FAST 4'h6
`define CLK_BASIC_FAST     4'h4
`define CLK_LONG_FAST      4'h8
// Instruction clocks, any other area
`define CLK_IMM_SADDR_SLOW 4'h8
`define CLK_BASIC_SLOW     4'h5
`define CLK_LONG_SLOW      4'h9
`define CLK_ONE            4'h1

// Instruction lengths in bytes
`define LEN_ONE            2'h1
`define LEN_TWO            2'h2
`define LEN_THREE          2'h3

// Arithmetic field positions and zero values
`define BORROW_BIT         8
`define AUX_BIT            4
`define BYTE_ZERO          8'h00
`define ADDR_ZERO          16'h0000

// CPU clock divider
`define DIV_SEL_MAX        3'h4
`define DIV_CNT_ZERO       4'h0

`endif

// ==== pkg/alu_pkg.sv ====
// Types shared by the subtract, logic and compare datapath
package alu_pkg;

    // Operations handled by the datapath
    typedef enum logic [2:0] {
        SUBTRACT_OP,
        SUBTRACT_BORROW_OP,
        AND_OP,
        OR_OP,
        XOR_OP,
        COMPARE_OP
    } op_e;

    // Operand forms
    typedef enum logic [3:0] {
        F_IMM_A,
        F_IMM_SADDR,
        F_A_R,
        F_R_A,
        F_A_SADDR,
        F_A_ABS,
        F_PTR,
        F_PTR_BYTE,
        F_PTR_B,
        F_PTR_C
    } form_e;

    // Request from the instruction decoder
    typedef struct packed {
        op_e         op;
        form_e       form;
        logic        in_fast_ram;
        logic [7:0]  dst;
        logic [7:0]  src;
        logic        carry_flag;
        logic        aux_carry_flag;
        logic [15:0] memory_pointer_pair;
        logic [7:0]  offset;
        logic [7:0]  idx_b;
        logic [7:0]  idx_c;
        logic [15:0] absolute_address;
        logic [15:0] short_address;
    } request_s;

    // Answer to the sequencer
    typedef struct packed {
        logic [7:0]  result;
        logic        write_dest;
        logic        zero_flag;
        logic        aux_carry_flag;
        logic        carry_flag;
        logic [15:0] mem_addr;
        logic [1:0]  length;
        logic [3:0]  clocks;
    } answer_s;

endpackage

// ==== rtl/cpu_tick_div.sv ====
// CPU clock enable divider steered by the clock select value
`timescale 1ns/10ps
`include "alu_consts.svh"

module cpu_tick_div
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Divide by two to the power of select, select above 4 taken as 4
    input  wire logic [2:0] select,
    // One-cycle enable per CPU clock
    output logic            tick_q
);

    logic [3:0] cnt_q;
    logic [2:0] sel;
    logic [3:0] last;

    // Clamp select, terminal count of the divider
    always_comb
    begin
        sel  = (select > `DIV_SEL_MAX) ? `DIV_SEL_MAX : select;
        last = 4'((5'h01 << sel) - 5'h01);
    end

    // Free-running count and tick
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= `DIV_CNT_ZERO;
            tick_q <= 1'b0;
        end
        else if (cnt_q >= last)
        begin
            cnt_q  <= `DIV_CNT_ZERO;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= 4'(cnt_q + 4'h1);
            tick_q <= 1'b0;
        end
    end

endmodule

// ==== rtl/sub_logic_alu.sv ====
// Subtract, borrow-subtract, AND, OR, XOR and compare datapath
`timescale 1ns/10ps
`include "alu_consts.svh"

// Summary of operation
// RL1: Subtract source from destination, store, carry on borrow, Z and aux.
// RL2: Borrow-subtract also takes carry in, stores, updates zero, aux, carry.
// RL3: Memory operand at pointer pair, plus byte, plus index B or C.
// RL4: AND stores conjunction, updates zero only, aux and carry kept.
// RL5: OR stores inclusive OR, updates zero only, aux and carry kept.
// RL6: XOR stores exclusive OR, updates zero only, aux and carry kept.
// RL7: Fast RAM clocks: 4 immediate-A, 6 immediate-short, 4 pointer, 8 long.
// RL8: Other area clocks: 8 immediate-short, 5 short or pointer, 9 long.
// RL9: Each instruction clock is one CPU clock from the clock select.
// RL10: Compare computes like subtract, updates flags, writes nothing back.
// RL11: Lengths: 2 immediate-A and register, 3 short-immediate and absolute.
module sub_logic_alu
    import alu_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // CPU clock choice
    input  wire logic [2:0] processor_clock_select_register,
    // Request from the decoder
    input  wire logic       start,
    input  wire request_s   req,
    // Answer
    output logic            busy_q,
    output logic            done_q,
    output answer_s         answer_q
);

    // ****************************************************************
    // Timing and length tables
    // ****************************************************************

    // Instruction clocks per form and area
    function automatic logic [3:0] clocks_for(form_e f, logic fast);
        unique case (f)
            F_IMM_A, F_A_R, F_R_A: clocks_for = `CLK_IMM_A; // RL7
            F_IMM_SADDR:
                clocks_for = fast ? `CLK_IMM_SADDR_FAST
                                  : `CLK_IMM_SADDR_SLOW; // RL8
            F_A_SADDR, F_PTR:
                clocks_for = fast ? `CLK_BASIC_FAST
                                  : `CLK_BASIC_SLOW; // RL8
            default:
                clocks_for = fast ? `CLK_LONG_FAST : `CLK_LONG_SLOW; // RL7
        endcase
    endfunction

    // Instruction bytes per form
    function automatic logic [1:0] length_for(form_e f);
        unique case (f)
            F_PTR:                  length_for = `LEN_ONE; // RL11
            F_IMM_SADDR, F_A_ABS:   length_for = `LEN_THREE; // RL11
            default:                length_for = `LEN_TWO; // RL11
        endcase
    endfunction

    // ****************************************************************
    // CPU clock enable
    // ****************************************************************

    logic tick;

    cpu_tick_div u_div
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .select (processor_clock_select_register),
        .tick_q (tick)
    );

    // ****************************************************************
    // Operation
    // ****************************************************************

    request_s   req_q;
    logic [3:0] left_q;
    logic       accept;
    logic       finish;
    logic [8:0] diff;
    logic [4:0] nib;
    logic       bin;
    logic [7:0] res;
    logic       ac;
    logic       cy;
    logic [15:0] addr;

    assign accept = start && !busy_q;
    assign finish = busy_q && tick && (left_q == `CLK_ONE);

    // Result and flags from the latched request
    always_comb
    begin
        bin  = (req_q.op == SUBTRACT_BORROW_OP) && req_q.carry_flag; // RL2
        diff = 9'({1'b0, req_q.dst} - {1'b0, req_q.src} - {8'h00, bin});
        nib  = 5'({1'b0, req_q.dst[3:0]} - {1'b0, req_q.src[3:0]}
                  - {4'h0, bin});
        ac   = req_q.aux_carry_flag;
        cy   = req_q.carry_flag;
        unique case (req_q.op)
            AND_OP: res = req_q.dst & req_q.src; // RL4
            OR_OP:  res = req_q.dst | req_q.src; // RL5
            XOR_OP: res = req_q.dst ^ req_q.src; // RL6
            default:
            begin
                res = diff[7:0]; // RL1
                ac  = nib[`AUX_BIT]; // RL1
                cy  = diff[`BORROW_BIT]; // RL1
            end
        endcase
    end

    // Memory address of the operand
    always_comb
    begin
        unique case (req_q.form)
            F_PTR:       addr = req_q.memory_pointer_pair; // RL3
            F_PTR_BYTE:  addr = 16'(req_q.memory_pointer_pair
                                    + {8'h00, req_q.offset}); // RL3
            F_PTR_B:     addr = 16'(req_q.memory_pointer_pair
                                    + {8'h00, req_q.idx_b}); // RL3
            F_PTR_C:     addr = 16'(req_q.memory_pointer_pair
                                    + {8'h00, req_q.idx_c}); // RL3
            F_A_ABS:     addr = req_q.absolute_address;
            F_IMM_SADDR, F_A_SADDR: addr = req_q.short_address;
            default:     addr = `ADDR_ZERO;
        endcase
    end

    // Request latch
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            req_q <= '0;
        else if (accept)
            req_q <= req;
    end

    // Instruction clock count, one per CPU clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            left_q <= `DIV_CNT_ZERO;
        end
        else if (accept)
        begin
            busy_q <= 1'b1;
            left_q <= clocks_for(req.form, req.in_fast_ram); // RL7 RL8
        end
        else if (busy_q && tick)
        begin
            left_q <= 4'(left_q - `CLK_ONE); // RL9
            if (left_q == `CLK_ONE)
                busy_q <= 1'b0;
        end
    end

    // Answer and completion pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_q   <= 1'b0;
            answer_q <= '0;
        end
        else
        begin
            done_q <= finish;
            if (finish)
            begin
                answer_q.result         <= res;
                answer_q.write_dest     <= req_q.op != COMPARE_OP; // RL10
                answer_q.zero_flag      <= res == `BYTE_ZERO;
                answer_q.aux_carry_flag <= ac;
                answer_q.carry_flag     <= cy;
                answer_q.mem_addr       <= addr;
                answer_q.length         <= length_for(req_q.form);
                answer_q.clocks <= clocks_for(req_q.form, req_q.in_fast_ram);
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    logic [3:0] ticks_q;

    // CPU clocks seen since the request was taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ticks_q <= `DIV_CNT_ZERO;
        else if (accept)
            ticks_q <= `DIV_CNT_ZERO;
        else if (busy_q && tick)
            ticks_q <= 4'(ticks_q + `CLK_ONE);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_accept;
        start && !busy_q;
    endsequence

    sequence s_done(op_e o);
        done_q && req_q.op == o;
    endsequence

    property p_sub;
        s_done(SUBTRACT_OP) |-> answer_q.result == 8'(req_q.dst - req_q.src)
            && answer_q.carry_flag == (req_q.src > req_q.dst)
            && answer_q.write_dest;
    endproperty
    a_sub: assert property (p_sub) else $error("subtract wrong"); // RL1

    property p_subb;
        s_done(SUBTRACT_BORROW_OP) |-> answer_q.result ==
            8'(req_q.dst - req_q.src - {7'h00, req_q.carry_flag});
    endproperty
    a_subb: assert property (p_subb) else $error("borrow wrong"); // RL2

    property p_ptr_b;
        done_q && req_q.form == F_PTR_B |-> answer_q.mem_addr ==
            16'(req_q.memory_pointer_pair + {8'h00, req_q.idx_b});
    endproperty
    a_ptr_b: assert property (p_ptr_b) else $error("index B wrong"); // RL3

    property p_and;
        s_done(AND_OP) |-> answer_q.result == (req_q.dst & req_q.src)
            && answer_q.carry_flag == req_q.carry_flag
            && answer_q.aux_carry_flag == req_q.aux_carry_flag;
    endproperty
    a_and: assert property (p_and) else $error("AND wrong"); // RL4

    property p_or;
        s_done(OR_OP) |-> answer_q.result == (req_q.dst | req_q.src)
            && answer_q.carry_flag == req_q.carry_flag;
    endproperty
    a_or: assert property (p_or) else $error("OR wrong"); // RL5

    property p_xor;
        s_done(XOR_OP) |-> answer_q.result == (req_q.dst ^ req_q.src)
            && answer_q.zero_flag == (req_q.dst == req_q.src);
    endproperty
    a_xor: assert property (p_xor) else $error("XOR wrong"); // RL6

    property p_fast_long;
        done_q && req_q.in_fast_ram && req_q.form == F_PTR_BYTE
            |-> ticks_q == `CLK_LONG_FAST;
    endproperty
    a_fast_long: assert property (p_fast_long) else $error("8 clk"); // RL7

    property p_slow_ptr;
        done_q && !req_q.in_fast_ram && req_q.form == F_PTR
            |-> ticks_q == `CLK_BASIC_SLOW;
    endproperty
    a_slow_ptr: assert property (p_slow_ptr) else $error("5 clk"); // RL8

    property p_tick_done;
        done_q |-> $past(tick) && ticks_q == answer_q.clocks;
    endproperty
    a_tick_done: assert property (p_tick_done) else $error("no tick"); // RL9

    property p_take;
        s_accept |=> busy_q && ticks_q == `DIV_CNT_ZERO;
    endproperty
    a_take: assert property (p_take) else $error("not taken"); // RL9

    property p_cmp;
        s_done(COMPARE_OP) |-> !answer_q.write_dest
            && answer_q.carry_flag == (req_q.src > req_q.dst);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare wrong"); // RL10

    property p_len;
        done_q && req_q.form == F_A_ABS |-> answer_q.length == `LEN_THREE;
    endproperty
    a_len: assert property (p_len) else $error("length wrong"); // RL11

endmodule

// ==== tb/alu_decoder_model.sv ====
// Decoder and sequencer model that feeds the datapath
`timescale 1ns/10ps
module alu_decoder_model
    import alu_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Datapath status
    input  wire logic done_q,
    // Request
    output request_s  req,
    output logic      start
);
    // Idle until the first request
    initial
    begin
        start = 1'b0;
        req   = '0;
    end

    // One-cycle strobe; fields scrambled once taken
    task automatic launch(input request_s r);
    begin
        start = 1'b1;
        req   = r;
        @(posedge clk);
        #1;
        start = 1'b0;
        req   = ~r;
    end
    endtask

    // Whole transfer; poke retries start while busy
    task automatic issue(input request_s r, input logic poke,
                         output int cyc);
    begin
        launch(r);
        cyc = 0;
        while (done_q !== 1'b1 && cyc < 300)
        begin
            @(posedge clk);
            #1;
            cyc++;
            start = poke && (cyc == 1);
        end
    end
    endtask
endmodule

// ==== tb/eight_bit_subtract_logic_compare_alu_bench.sv ====
// Self-checking bench for the subtract, logic and compare datapath
`timescale 1ns/10ps
module eight_bit_subtract_logic_compare_alu_bench
    import alu_pkg::*;
;
    // One case: operation, operands, flags in, retry
    typedef struct packed {
        op_e        op;
        form_e      form;
        logic       fast;
        logic [7:0] d;
        logic [7:0] s;
        logic       cy;
        logic       ac;
        logic       poke;
    } row_s;

    logic       clk;
    logic       rst_n;
    logic [2:0] processor_clock_select_register;
    logic       start;
    request_s   req;
    logic       busy_q;
    logic       done_q;
    answer_s    answer_q;
    int         err_total;
    int         n_tests;
    row_s       rows [0:14] = '{
        '{SUBTRACT_OP, F_IMM_A, 1'b1, 8'h10, 8'h01, 1'b0, 1'b0, 1'b0},
        '{SUBTRACT_OP, F_A_SADDR, 1'b0, 8'h05, 8'h07, 1'b0, 1'b0, 1'b0},
        '{SUBTRACT_BORROW_OP, F_A_R, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0},
        '{SUBTRACT_BORROW_OP, F_IMM_SADDR,
          1'b1, 8'h34, 8'h33, 1'b1, 1'b0, 1'b0},
        '{SUBTRACT_BORROW_OP, F_IMM_SADDR,
          1'b0, 8'h80, 8'h01, 1'b0, 1'b1, 1'b0},
        '{AND_OP, F_R_A, 1'b1, 8'hf0, 8'h0f, 1'b1, 1'b1, 1'b0},
        '{AND_OP, F_PTR, 1'b0, 8'hff, 8'h3c, 1'b0, 1'b1, 1'b0},
        '{OR_OP, F_PTR, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0},
        '{OR_OP, F_PTR_BYTE, 1'b0, 8'ha0, 8'h05, 1'b0, 1'b0, 1'b0},
        '{XOR_OP, F_PTR_B, 1'b1, 8'h5a, 8'h5a, 1'b1, 1'b1, 1'b0},
        '{XOR_OP, F_PTR_C, 1'b0, 8'h5a, 8'ha5, 1'b0, 1'b0, 1'b0},
        '{COMPARE_OP, F_A_ABS, 1'b1, 8'h42, 8'h42, 1'b1, 1'b0, 1'b0},
        '{COMPARE_OP, F_A_ABS, 1'b0, 8'h01, 8'h02, 1'b0, 1'b0, 1'b1},
        '{COMPARE_OP, F_PTR_C, 1'b1, 8'h90, 8'h0f, 1'b0, 1'b0, 1'b0},
        '{SUBTRACT_OP, F_PTR_BYTE, 1'b1, 8'h00, 8'h01, 1'b0, 1'b0, 1'b1}
    };

    // ********************
    // Devices and clock
    // ********************
    sub_logic_alu sub_logic_alu_inst (.clk(clk), .rst_n(rst_n),
        .processor_clock_select_register(processor_clock_select_register),
        .start(start), .req(req), .busy_q(busy_q), .done_q(done_q),
        .answer_q(answer_q));
    alu_decoder_model alu_decoder_model_inst (.clk(clk), .done_q(done_q),
        .req(req), .start(start));
    always #50 clk = ~clk;

    // Comparisons
    task automatic chk_v(input string what, input logic [15:0] e,
                         input logic [15:0] g);
    begin
        n_tests++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", what, e, g);
            err_total++;
        end
    end
    endtask

    task automatic chk_b(input string what, input logic e, input logic g);
    begin
        chk_v(what, 16'(e), 16'(g));
    end
    endtask

    // Request with fixed pointer and address fields
    function automatic request_s mk(input row_s w);
        request_s r;
        r = '0;
        r.op = w.op;
        r.form = w.form;
        r.in_fast_ram = w.fast;
        r.dst = w.d;
        r.src = w.s;
        r.carry_flag = w.cy;
        r.aux_carry_flag = w.ac;
        r.memory_pointer_pair = 16'h12f0;
        r.offset = 8'h15;
        r.idx_b = 8'h21;
        r.idx_c = 8'h42;
        r.absolute_address = 16'hbe0c;
        r.short_address = 16'hfe20;
        return r;
    endfunction

    // Run one case and check every answer field, the result except for compare
    task automatic run_row(input row_s w, input int div);
        logic [8:0]  df;
        logic [4:0]  nb;
        logic [7:0]  res;
        logic [15:0] ma;
        logic        lg;
        int          n;
        int          ln;
        int          cyc;
    begin
        df = {1'b0, w.d} - {1'b0, w.s}
             - 9'(w.op == SUBTRACT_BORROW_OP && w.cy);
        nb = {1'b0, w.d[3:0]} - {1'b0, w.s[3:0]}
             - 5'(w.op == SUBTRACT_BORROW_OP && w.cy);
        lg = w.op inside {AND_OP, OR_OP, XOR_OP};
        res = (w.op == AND_OP) ? (w.d & w.s) : (w.op == OR_OP) ? (w.d | w.s)
            : (w.op == XOR_OP) ? (w.d ^ w.s) : df[7:0];
        case (w.form)
            F_IMM_SADDR: n = w.fast ? 6 : 8;
            F_A_SADDR, F_PTR: n = w.fast ? 4 : 5;
            F_IMM_A, F_A_R, F_R_A: n = 4;
            default: n = w.fast ? 8 : 9;
        endcase
        ln = (w.form == F_PTR) ? 1
           : (w.form inside {F_IMM_SADDR, F_A_ABS}) ? 3 : 2;
        case (w.form)
            F_PTR: ma = 16'h12f0;
            F_PTR_BYTE: ma = 16'h1305;
            F_PTR_B: ma = 16'h1311;
            F_PTR_C: ma = 16'h1332;
            F_A_ABS: ma = 16'hbe0c;
            F_IMM_SADDR, F_A_SADDR: ma = 16'hfe20;
            default: ma = 16'h0000;
        endcase
        alu_decoder_model_inst.issue(mk(w), w.poke, cyc);
        chk_b("done", 1'b1, done_q);
        chk_b("busy", 1'b0, busy_q);
        if (w.op != COMPARE_OP)
            chk_v("result", 16'(res),
                  16'(answer_q.result));
        chk_b("write_dest", w.op != COMPARE_OP, answer_q.write_dest);
        chk_b("zero", res == 8'h00, answer_q.zero_flag);
        chk_b("carry", lg ? w.cy : df[8], answer_q.carry_flag);
        chk_b("aux", lg ? w.ac : nb[4], answer_q.aux_carry_flag);
        chk_v("mem_addr", ma, answer_q.mem_addr);
        chk_v("length", 16'(ln), 16'(answer_q.length));
        chk_v("clocks", 16'(n), 16'(answer_q.clocks));
        if (div == 1)
            chk_v("cycles", 16'(n), 16'(cyc));
        else
            chk_b("cycles", 1'b1, cyc > div * (n - 1)
                  && cyc <= div * (n + 1) + 1);
    end
    endtask

    // Counts, verdict and end of run
    task automatic wrap_up;
    begin
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        processor_clock_select_register = 3'h0;
        err_total = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk_b("busy", 1'b0, busy_q);
        chk_b("answer", 1'b1, answer_q === '0);
        // Table cases, back to back
        foreach (rows[i])
            run_row(rows[i], 1);
        // Clock selects 1 to 5, the last one clamped
        for (int k = 1; k < 6; k++)
        begin
            processor_clock_select_register = 3'(k);
            run_row(rows[2], 1 << ((k > 4) ? 4 : k));
        end
        // Reset in mid-operation
        alu_decoder_model_inst.launch(mk(rows[4]));
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        #10;
        chk_b("busy", 1'b0, busy_q);
        chk_b("done", 1'b0, done_q);
        chk_b("answer", 1'b1, answer_q === '0);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        run_row(rows[12], 16);
        wrap_up();
    end

    // Watchdog against a hang
    initial
    begin
        #(4000 * 100);
        err_total++;
        wrap_up();
    end
endmodule
